// >>> shared/css_cfg.svh
// constants for the clock source select and failsafe block
`ifndef CSS_CFG_SVH
`define CSS_CFG_SVH
// ---------------------------------------------------------------
// register indices; byte address is four times the index
// ---------------------------------------------------------------
`define CSS_CTRL_INDEX 12'hF86
`define CSS_STAT_INDEX 12'hF87
`define CSS_CTRL_RESET 8'hA0
// ---------------------------------------------------------------
// control field positions
// ---------------------------------------------------------------
`define CSS_BIT_RC_EN 7
`define CSS_BIT_XTAL_EN 6
`define CSS_BIT_WDOSC_EN 5
`define CSS_BIT_PFD_EN 4
`define CSS_BIT_WFD_EN 3
`define CSS_SEL_HI 2
`define CSS_SEL_LO 0
// ---------------------------------------------------------------
// status field positions
// ---------------------------------------------------------------
`define CSS_ST_PRI_FAIL 0
`define CSS_ST_WDOG_FAIL 1
`define CSS_ST_FALLBACK 2
`define CSS_ST_WDOG_DEAD 3
`define CSS_ST_UL_LO 4
`define CSS_ST_SEL_LO 8
// ---------------------------------------------------------------
// unlock keys and bus answers
// ---------------------------------------------------------------
`define CSS_KEY_FIRST 8'hE7
`define CSS_KEY_SECOND 8'h18
`define CSS_RESP_OKAY 2'h0
`define CSS_RESP_SLVERR 2'h2
// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define CSS_CLK_PERIOD_NS 10
`define CSS_PRI_FAIL_PERIOD_NS 1000000
`define CSS_PRI_FAIL_CYC ((`CSS_PRI_FAIL_PERIOD_NS + `CSS_CLK_PERIOD_NS - 1) / `CSS_CLK_PERIOD_NS)
`define CSS_WDOG_FAIL_CLOCKS 8004
`endif

// >>> shared/css_pkg.sv
// types shared by the clock source select and failsafe block
package css_pkg;
  // unlock sequencer states
  typedef enum logic [1:0] {
    CSS_UL_LOCKED = 2'b00,
    CSS_UL_KEY1 = 2'b01,
    CSS_UL_OPEN = 2'b10
  } css_unlock_e;
  // source select codes; 101..111 are reserved
  typedef enum logic [2:0] {
    CSS_SEL_RC_FAST = 3'b000,
    CSS_SEL_RC_SLOW = 3'b001,
    CSS_SEL_XTAL = 3'b010,
    CSS_SEL_WDOG = 3'b011,
    CSS_SEL_EXT = 3'b100
  } css_src_e;
  // register decode result
  typedef enum logic [1:0] {
    CSS_DEC_NONE = 2'b00,
    CSS_DEC_CTRL = 2'b01,
    CSS_DEC_STAT = 2'b10
  } css_dec_e;
endpackage : css_pkg

// >>> verilog/css_stall_timer.sv
// stall timer: flags when ticks pass with no restart
`timescale 1ns/10ps
module css_stall_timer #(
  parameter int unsigned LIMIT = 8004,
  parameter int W = $clog2(LIMIT + 1)
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic run,
  input wire logic tick,
  input wire logic restart,
  output logic expired,
  output logic timed_out
);
  localparam logic [W-1:0] LAST = W'(LIMIT - 1);
  logic [W-1:0] cnt_r; // ticks since last restart
  // count ticks; a restart or stop clears everything
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r <= '0;
      timed_out <= 1'b0;
      expired <= 1'b0;
    end else if (ce) begin
      expired <= 1'b0;
      if (!run || restart) begin
        cnt_r <= '0;
        timed_out <= 1'b0;
      end else if (tick && !timed_out) begin
        if (cnt_r == LAST) begin
          timed_out <= 1'b1;
          expired <= 1'b1;
        end else begin
          cnt_r <= cnt_r + 1'b1;
        end
      end
    end
  end
  chk_count_reach_limit: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(timed_out) |-> $past(cnt_r) == LAST && $past(tick) && !$past(restart))
    else $error("timer expired before its limit");
endmodule : css_stall_timer

// >>> verilog/css_glitchless_mux.sv
// glitch-free source multiplexer for the sampled clock levels
`timescale 1ns/10ps
module css_glitchless_mux (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [4:0] src_lvl,
  input wire logic [2:0] want_sel,
  output logic sys_clk,
  output logic sys_rise,
  output logic [2:0] cur_sel
);
  // level of one source; reserved codes give a dead low
  function automatic logic pick(input logic [4:0] lvl, input logic [2:0] sel);
    pick = (sel <= 3'h4) ? lvl[sel] : 1'b0;
  endfunction : pick
  logic sys_clk_nxt; // level of the active source
  logic want_lvl; // level of the requested source
  assign sys_clk_nxt = pick(src_lvl, cur_sel);
  assign want_lvl = pick(src_lvl, want_sel);
  // switch only while both old and new sources sit low
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cur_sel <= css_pkg::CSS_SEL_RC_FAST;
    end else if (ce && want_sel != cur_sel && !sys_clk_nxt && !want_lvl) begin
      cur_sel <= want_sel;
    end
  end
  // output level and its rising edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sys_clk <= 1'b0;
      sys_rise <= 1'b0;
    end else if (ce) begin
      sys_clk <= sys_clk_nxt;
      sys_rise <= sys_clk_nxt && !sys_clk;
    end
  end
  chk_no_runt_pulse: assert property (@(posedge aclk) disable iff (!aresetn)
    $changed(cur_sel) |-> !sys_clk && !$past(want_lvl))
    else $error("source switched while the clock was high");
endmodule : css_glitchless_mux

// >>> verilog/css_clock_ctrl.sv
// clock source select, unlock sequencer and failure supervision
//
// Notes on behaviour
// - five selectable system clock schemes
// - unlock with E7h then 18h, next write commits
// - any other write pattern changes nothing
// - keys ordered, other accesses may interleave
// - internal oscillator on at reset, never auto-off
// - primary failure raises non-maskable event
// - primary failure falls back to watchdog oscillator
// - no fallback if watchdog selected or off
// - primary failure below about one kilohertz
// - watchdog failure raises event, source unchanged
// - after watchdog failure primary detection stops
// - watchdog failure after 8004 clocks without edge
// - all sources and detection off halts
// - select codes 000 to 100, rest reserved
// - control field layout from bit seven down
//
// Our own choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/10ps
`include "css_cfg.svh"
module css_clock_ctrl #(
  parameter int ADDR_W = 16,
  parameter int unsigned PRI_FAIL_CYC = `CSS_PRI_FAIL_CYC,
  parameter int unsigned WDOG_FAIL_CLOCKS = `CSS_WDOG_FAIL_CLOCKS
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // register bus
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // sampled oscillator levels
  input wire logic rc_fast_clk,
  input wire logic rc_slow_clk,
  input wire logic crystal_clk,
  input wire logic wdog_osc_clk,
  input wire logic external_clock_port_pin,
  // oscillator enables and clock result
  output logic internal_rc_enable,
  output logic crystal_enable,
  output logic wdog_osc_enable,
  output logic sys_clk,
  output logic sys_clk_rise,
  output logic [2:0] clock_source_select,
  // failure events and state
  output logic primary_fail_event,
  output logic wdog_fail_event,
  output logic fallback_active
);
  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  // word index of a byte address; low two bits ignored
  function automatic css_pkg::css_dec_e decode(input logic [ADDR_W-1:0] addr);
    if (addr[ADDR_W-1:2] == (ADDR_W-2)'(`CSS_CTRL_INDEX)) begin
      decode = css_pkg::CSS_DEC_CTRL;
    end else if (addr[ADDR_W-1:2] == (ADDR_W-2)'(`CSS_STAT_INDEX)) begin
      decode = css_pkg::CSS_DEC_STAT;
    end else begin
      decode = css_pkg::CSS_DEC_NONE;
    end
  endfunction : decode

  // ---------------------------------------------------------------
  // state declarations
  // ---------------------------------------------------------------
  logic [7:0] clock_source_control_reg; // control register
  css_pkg::css_unlock_e ul_state_r; // unlock sequencer
  logic fallback_r; // running on watchdog oscillator after failure
  logic wdog_dead_r; // watchdog oscillator found dead
  logic pri_flag_r; // sticky primary failure flag
  logic wdog_flag_r; // sticky watchdog failure flag
  logic wdog_prev_r; // last watchdog level, edge detect
  logic aw_have_r; // write address held
  logic w_have_r; // write data held
  logic [ADDR_W-1:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic w_lane0_r; // low byte lane strobed
  logic pri_exp; // primary timer expiry pulse
  logic wdog_exp; // watchdog timer expiry pulse
  logic [2:0] want_sel; // source asked of the mux
  logic [4:0] src_lvl; // gated source levels by select code
  logic wdog_lvl; // watchdog oscillator, gated by its enable
  logic do_write; // both halves of a write are held
  logic wr_ctrl; // committed-or-not write to control
  logic wr_stat; // write to status

  // field views of the control register
  logic primary_fail_detect_en;
  logic wdog_osc_fail_detect_en;
  logic [2:0] sel_field;
  assign internal_rc_enable = clock_source_control_reg[`CSS_BIT_RC_EN];
  assign crystal_enable = clock_source_control_reg[`CSS_BIT_XTAL_EN];
  assign wdog_osc_enable = clock_source_control_reg[`CSS_BIT_WDOSC_EN];
  assign primary_fail_detect_en = clock_source_control_reg[`CSS_BIT_PFD_EN];
  assign wdog_osc_fail_detect_en = clock_source_control_reg[`CSS_BIT_WFD_EN];
  assign sel_field = clock_source_control_reg[`CSS_SEL_HI:`CSS_SEL_LO];
  assign fallback_active = fallback_r;

  // ---------------------------------------------------------------
  // write channel
  // ---------------------------------------------------------------
  // each half is taken on its own; the reply waits for both
  assign awready = ce && !aw_have_r && !bvalid;
  assign wready = ce && !w_have_r && !bvalid;
  assign do_write = ce && aw_have_r && w_have_r && !bvalid;
  // a write without the low lane touches no byte of our registers
  assign wr_ctrl = do_write && w_lane0_r && decode(aw_addr_r) == css_pkg::CSS_DEC_CTRL;
  assign wr_stat = do_write && w_lane0_r && decode(aw_addr_r) == css_pkg::CSS_DEC_STAT;

  // hold address and data until the write is done
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      aw_addr_r <= '0;
      w_data_r <= 32'h0000_0000;
      w_lane0_r <= 1'b0;
    end else if (ce) begin
      if (awvalid && awready) begin
        aw_have_r <= 1'b1;
        aw_addr_r <= awaddr;
      end else if (do_write) begin
        aw_have_r <= 1'b0;
      end
      if (wvalid && wready) begin
        w_have_r <= 1'b1;
        w_data_r <= wdata;
        w_lane0_r <= wstrb[0];
      end else if (do_write) begin
        w_have_r <= 1'b0;
      end
    end
  end

  // write response; unmapped addresses answer with an error
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= `CSS_RESP_OKAY;
    end else if (ce) begin
      if (do_write) begin
        bvalid <= 1'b1;
        bresp <= (decode(aw_addr_r) == css_pkg::CSS_DEC_NONE) ? `CSS_RESP_SLVERR : `CSS_RESP_OKAY;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // read channel
  // ---------------------------------------------------------------
  assign arready = ce && !rvalid;

  // reads have no side effect, so they never disturb unlocking
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= `CSS_RESP_OKAY;
    end else if (ce) begin
      if (arvalid && arready) begin
        rvalid <= 1'b1;
        rresp <= `CSS_RESP_OKAY;
        case (decode(araddr))
          css_pkg::CSS_DEC_CTRL: begin
            rdata <= {24'h000000, clock_source_control_reg};
          end
          css_pkg::CSS_DEC_STAT: begin
            rdata <= {21'h000000, clock_source_select, 2'b00, ul_state_r,
                      wdog_dead_r, fallback_r, wdog_flag_r, pri_flag_r};
          end
          default: begin
            rdata <= 32'h0000_0000;
            rresp <= `CSS_RESP_SLVERR;
          end
        endcase
      end else if (rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // unlock sequencer
  // ---------------------------------------------------------------
  // only control writes move it; other traffic is invisible
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ul_state_r <= css_pkg::CSS_UL_LOCKED;
    end else if (wr_ctrl) begin
      case (ul_state_r)
        css_pkg::CSS_UL_LOCKED: begin
          if (w_data_r[7:0] == `CSS_KEY_FIRST) begin
            ul_state_r <= css_pkg::CSS_UL_KEY1;
          end
        end
        css_pkg::CSS_UL_KEY1: begin
          // a repeated first key keeps the sequence alive
          if (w_data_r[7:0] == `CSS_KEY_SECOND) begin
            ul_state_r <= css_pkg::CSS_UL_OPEN;
          end else if (w_data_r[7:0] != `CSS_KEY_FIRST) begin
            ul_state_r <= css_pkg::CSS_UL_LOCKED;
          end
        end
        css_pkg::CSS_UL_OPEN: begin
          ul_state_r <= css_pkg::CSS_UL_LOCKED;
        end
        default: begin
          ul_state_r <= css_pkg::CSS_UL_LOCKED;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // control register
  // ---------------------------------------------------------------
  // commits only from the open state; reserved select keeps the old
  // source because a dead select would stop the chip for good
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clock_source_control_reg <= `CSS_CTRL_RESET;
    end else if (wr_ctrl && ul_state_r == css_pkg::CSS_UL_OPEN) begin
      clock_source_control_reg[7:3] <= w_data_r[7:3];
      if (w_data_r[2:0] <= css_pkg::CSS_SEL_EXT) begin
        clock_source_control_reg[2:0] <= w_data_r[2:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // source selection
  // ---------------------------------------------------------------
  // disabled oscillators read as stopped; the pin has no enable
  assign wdog_lvl = wdog_osc_clk && wdog_osc_enable;
  assign src_lvl = {external_clock_port_pin, wdog_lvl, crystal_clk && crystal_enable,
                    rc_slow_clk && internal_rc_enable, rc_fast_clk && internal_rc_enable};
  // fallback overrides the programmed choice; with every source off
  // and detection off the clock simply stops until a committed control write enables a source
  assign want_sel = fallback_r ? css_pkg::CSS_SEL_WDOG : sel_field;

  css_glitchless_mux u_mux (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .src_lvl(src_lvl),
    .want_sel(want_sel),
    .sys_clk(sys_clk),
    .sys_rise(sys_clk_rise),
    .cur_sel(clock_source_select)
  );

  // ---------------------------------------------------------------
  // failure detectors
  // ---------------------------------------------------------------
  // primary: bus cycles with no system clock edge; silent after a
  // watchdog failure and while already fallen back
  css_stall_timer #(
    .LIMIT(PRI_FAIL_CYC)
  ) u_pri_timer (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .run(primary_fail_detect_en && !wdog_dead_r && !fallback_r),
    .tick(1'b1),
    .restart(sys_clk_rise),
    .expired(pri_exp),
    .timed_out()
  );

  // watchdog: system clocks with no watchdog edge
  css_stall_timer #(
    .LIMIT(WDOG_FAIL_CLOCKS)
  ) u_wdog_timer (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .run(wdog_osc_fail_detect_en && !wdog_dead_r),
    .tick(sys_clk_rise),
    .restart(wdog_lvl && !wdog_prev_r),
    .expired(wdog_exp),
    .timed_out()
  );

  // watchdog edge detector history
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wdog_prev_r <= 1'b0;
    end else if (ce) begin
      wdog_prev_r <= wdog_lvl;
    end
  end

  // event pulses to the interrupt controller
  assign primary_fail_event = ce && pri_exp;
  assign wdog_fail_event = ce && wdog_exp;

  // fallback and the dead watchdog latch; neither touches the control
  // register, any committed control write ends the fallback
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fallback_r <= 1'b0;
      wdog_dead_r <= 1'b0;
    end else if (ce) begin
      if (pri_exp && wdog_osc_enable && sel_field != css_pkg::CSS_SEL_WDOG) begin
        fallback_r <= 1'b1;
      end else if (wr_ctrl && ul_state_r == css_pkg::CSS_UL_OPEN) begin
        fallback_r <= 1'b0;
      end
      if (wdog_exp) begin
        wdog_dead_r <= 1'b1;
      end
    end
  end

  // sticky flags: write one to clear, a new event wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pri_flag_r <= 1'b0;
      wdog_flag_r <= 1'b0;
    end else if (ce) begin
      pri_flag_r <= pri_exp || (pri_flag_r && !(wr_stat && w_data_r[`CSS_ST_PRI_FAIL]));
      wdog_flag_r <= wdog_exp || (wdog_flag_r && !(wr_stat && w_data_r[`CSS_ST_WDOG_FAIL]));
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence ctrl_commit;
    wr_ctrl && ul_state_r == css_pkg::CSS_UL_OPEN;
  endsequence
  // helper: last control write was a first key outside the open state;
  // other traffic in between leaves it alone
  logic key_armed_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      key_armed_r <= 1'b0;
    end else if (wr_ctrl) begin
      key_armed_r <= w_data_r[7:0] == `CSS_KEY_FIRST && ul_state_r != css_pkg::CSS_UL_OPEN;
    end
  end
  sequence key_pair;
    wr_ctrl && key_armed_r && w_data_r[7:0] == `CSS_KEY_SECOND;
  endsequence

  chk_unlock_open: assert property (@(posedge aclk) disable iff (!aresetn)
    key_pair |=> ul_state_r == css_pkg::CSS_UL_OPEN)
    else $error("key pair did not open the register");
  chk_commit_locks: assert property (@(posedge aclk) disable iff (!aresetn)
    ctrl_commit |=> ul_state_r == css_pkg::CSS_UL_LOCKED)
    else $error("register stayed open after commit");
  chk_locked_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    $changed(clock_source_control_reg) |-> $past(wr_ctrl) && $past(ul_state_r) == css_pkg::CSS_UL_OPEN)
    else $error("control changed without unlock");
  chk_reset_relock: assert property (@(posedge aclk)
    !aresetn |=> ul_state_r == css_pkg::CSS_UL_LOCKED && clock_source_control_reg == `CSS_CTRL_RESET)
    else $error("reset left sequencer open");
  chk_fallback_taken: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && pri_exp && wdog_osc_enable && sel_field != css_pkg::CSS_SEL_WDOG |=> fallback_r)
    else $error("no fallback after primary failure");
  chk_no_fallback: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(fallback_r) |-> $past(wdog_osc_enable) && $past(sel_field) != css_pkg::CSS_SEL_WDOG)
    else $error("fallback taken when not allowed");
  chk_wdog_keeps_src: assert property (@(posedge aclk) disable iff (!aresetn)
    wdog_fail_event && !wr_ctrl && !pri_exp |=> $stable(clock_source_control_reg) && $stable(fallback_r))
    else $error("watchdog failure changed the source");
  chk_dead_no_pri: assert property (@(posedge aclk) disable iff (!aresetn)
    wdog_dead_r |=> !primary_fail_event)
    else $error("primary detection after watchdog failure");
  chk_pri_event: assert property (@(posedge aclk) disable iff (!aresetn)
    primary_fail_event |-> $past(primary_fail_detect_en) && !$past(wdog_dead_r))
    else $error("primary event without detection");
endmodule : css_clock_ctrl

// >>> tb/css_osc_model.sv
// oscillator and clock pin model facing the clock source block
`timescale 1ns/10ps
module css_osc_model #(
  parameter int WAIT = 20
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic rc_en,
  input wire logic xtal_en,
  input wire logic wd_en,
  input wire logic [4:0] stop,
  output logic [4:0] lvl
);
  logic [3:0] div_r; // free divider for all sources
  logic [7:0] xw_r; // crystal settle count
  logic [7:0] ww_r; // watchdog oscillator start-up count
  // crystal and watchdog oscillator start only after settling, so an early select sees a dead clock
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_r <= 4'h0;
      xw_r <= 8'h00;
      ww_r <= 8'h00;
    end else begin
      div_r <= div_r + 4'h1;
      xw_r <= !xtal_en ? 8'h00 : (xw_r == 8'(WAIT)) ? xw_r : xw_r + 8'h01;
      ww_r <= !wd_en ? 8'h00 : (ww_r == 8'(WAIT)) ? ww_r : ww_r + 8'h01;
    end
  end
  // a stopped or disabled oscillator rests at 0
  assign lvl[0] = rc_en & div_r[0] & !stop[0];
  assign lvl[1] = rc_en & div_r[3] & !stop[1];
  assign lvl[2] = xtal_en & (xw_r == 8'(WAIT)) & div_r[1] & !stop[2];
  assign lvl[3] = wd_en & (ww_r == 8'(WAIT)) & div_r[2] & !stop[3];
  assign lvl[4] = div_r[1] & !stop[4];
endmodule : css_osc_model

// >>> tb/clock_source_select_failsafe_tb_top.sv
// self-checking bench for the clock source select and failsafe block
`timescale 1ns/10ps
`include "css_cfg.svh"
module clock_source_select_failsafe_tb_top;
  localparam logic [15:0] CA = {2'b00, `CSS_CTRL_INDEX, 2'b00}; // control byte address
  localparam logic [15:0] SA = {2'b00, `CSS_STAT_INDEX, 2'b00}; // status byte address
  localparam logic [15:0] NA = 16'h0040; // unmapped
  logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [15:0] awaddr = 16'h0000, araddr = 16'h0000;
  logic [31:0] wdata = 32'h0, seed = 32'h1F990B80, rdata;
  logic [4:0] stop = 5'h00, lvl;
  logic [3:0] wstrb = 4'hF;
  logic ce = 1'b1, lane0 = 1'b1;
  logic [1:0] bresp, rresp;
  logic awready, wready, bvalid, arready, rvalid, rc_en, xt_en, wd_en, sys_clk, rise, pev, wev, fb;
  logic [2:0] sel;
  logic [33:0] q[$]; // expected {resp, data}, oldest first
  int miscompares = 0, checks = 0, n;
  always #5 aclk = ~aclk;
  // small counts keep failure detection quick
  css_clock_ctrl #(.ADDR_W(16), .PRI_FAIL_CYC(40), .WDOG_FAIL_CLOCKS(6)) dut (
    .aclk(aclk), .aresetn(aresetn), .ce(ce), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .rc_fast_clk(lvl[0]), .rc_slow_clk(lvl[1]), .crystal_clk(lvl[2]),
    .wdog_osc_clk(lvl[3]), .external_clock_port_pin(lvl[4]), .internal_rc_enable(rc_en),
    .crystal_enable(xt_en), .wdog_osc_enable(wd_en), .sys_clk(sys_clk), .sys_clk_rise(rise),
    .clock_source_select(sel), .primary_fail_event(pev), .wdog_fail_event(wev), .fallback_active(fb));
  css_osc_model #(.WAIT(20)) osc (.aclk(aclk), .aresetn(aresetn), .rc_en(rc_en), .xtal_en(xt_en),
    .wd_en(wd_en), .stop(stop), .lvl(lvl));
  // compare one value against its expectation
  task automatic chk(input logic [33:0] s, input logic [33:0] e);
    checks++;
    if (s !== e) begin
      miscompares++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic conclude;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : conclude
  task automatic lost;
    miscompares++;
    conclude();
  endtask : lost
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs
  // one write; random upper bits must be ignored
  task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic [1:0] r);
    int k;
    logic [31:0] x;
    x = xs();
    q.push_back({r, 32'h0});
    @(posedge aclk);
    awaddr <= a;
    wdata <= {x[31:8], d};
    wstrb <= {x[3:1], lane0};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (k = 0; k < 100; k++) begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    bready <= 1'b0;
    if (k == 100) lost();
  endtask : wr
  task automatic rd(input logic [15:0] a, input logic [33:0] e);
    int k;
    q.push_back(e);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (k = 0; k < 100; k++) begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    rready <= 1'b0;
    if (k == 100) lost();
  endtask : rd
  // unlock pair then a committing write
  task automatic cm(input logic [7:0] b);
    wr(CA, 8'hE7, 2'h0);
    wr(CA, 8'h18, 2'h0);
    wr(CA, b, 2'h0);
  endtask : cm
  // wait for the mux to land on a source
  task automatic ws(input logic [2:0] s);
    int k;
    for (k = 0; k < 200 && sel !== s; k++) @(posedge aclk);
    chk({31'h0, sel}, {31'h0, s});
    if (k == 200) conclude();
  endtask : ws
  // count event pulses over a window
  task automatic cnt(input int i, input int l);
    n = 0;
    repeat (l) begin
      @(posedge aclk);
      if ((i ? wev : pev) === 1'b1) n++;
    end
  endtask : cnt
  // response watcher takes the oldest note
  always @(posedge aclk) begin
    if ((rvalid & rready) === 1'b1) chk({rresp, rdata}, q.pop_front());
    if ((bvalid & bready) === 1'b1) chk({bresp, 32'h0}, q.pop_front());
  end
  initial begin
    repeat (20000) @(posedge aclk);
    lost();
  end
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(CA, 34'h0A0);
    rd(SA, 34'h0);
    rd(NA, 34'h200000000);
    wr(NA, 8'h5A, 2'h2);
    wr(CA, 8'h00, 2'h0);
    rd(CA, 34'h0A0);
    cm(8'h00);
    wr(CA, 8'h55, 2'h0);
    rd(CA, 34'h000);
    wr(CA, 8'hE7, 2'h0);
    rd(SA, 34'h010);
    wr(NA, 8'h18, 2'h2);
    wr(CA, 8'h18, 2'h0);
    lane0 = 1'b0;
    wr(CA, 8'h00, 2'h0);
    lane0 = 1'b1;
    rd(SA, 34'h020);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    wr(CA, 8'h00, 2'h0);
    rd(CA, 34'h0A0);
    cm(8'hE0);
    repeat (30) @(posedge aclk);
    for (int s = 0; s < 5; s++) begin
      cm(8'(8'hE0 + s));
      ws(3'(s));
      rd(CA, 34'(8'hE0 + s));
      rd(SA, 34'(s << 8));
    end
    cm(8'hE5);
    rd(CA, 34'h0E4);
    cm(8'hE2);
    ws(3'h2);
    cm(8'hF2);
    stop[2] <= 1'b1;
    ce <= 1'b0;
    cnt(0, 100);
    chk(34'(n), 34'h0);
    ce <= 1'b1;
    cnt(0, 100);
    chk(34'(n), 34'h1);
    chk({33'h0, fb}, 34'h1);
    cm(8'hD2);
    cnt(0, 100);
    chk(34'(n), 34'h1);
    chk({33'h0, fb}, 34'h0);
    chk({31'h0, rc_en, xt_en, wd_en}, 34'h6);
    stop[3] <= 1'b1;
    stop[2] <= 1'b0;
    cm(8'hEA);
    cnt(1, 150);
    chk(34'(n), 34'h1);
    chk({31'h0, sel}, 34'h2);
    cm(8'hFA);
    stop[2] <= 1'b1;
    cnt(0, 150);
    chk(34'(n), 34'h0);
    conclude();
  end
endmodule : clock_source_select_failsafe_tb_top
